// ### core/gtu_defines.vh
// Register map, field positions and reset values of the timer unit
`ifndef GTU_DEFINES_VH
`define GTU_DEFINES_VH
// Register word indexes, byte address = index * 4
`define GTU_IDX_CTL0 6'h00
`define GTU_IDX_CNT0 6'h05
`define GTU_IDX_CAPTURE_RELOAD_REG 6'h0A
`define GTU_IDX_CRCTL 6'h0B
`define GTU_IDX_STAT 6'h0C
// Timer control fields
`define GTU_F_MODE 1:0
`define GTU_F_RUN 2
`define GTU_F_DOWN 3
`define GTU_F_EXTDIR 4
`define GTU_F_GPOL 5
`define GTU_F_EDGE 7:6
`define GTU_F_PS 10:8
`define GTU_F_OUTEN 11
`define GTU_F_AUXFN 13:12
`define GTU_F_RLSEL 15:14
// Basic modes
`define GTU_MODE_TIMER 2'h0
`define GTU_MODE_GATED 2'h1
`define GTU_MODE_COUNT 2'h2
`define GTU_MODE_ENC 2'h3
// Auxiliary timer roles
`define GTU_AUX_NONE 2'h0
`define GTU_AUX_RELOAD 2'h1
`define GTU_AUX_CAPTURE 2'h2
`define GTU_AUX_CHAIN 2'h3
// Capture/reload control fields
`define GTU_F_CAPSRC 1:0
`define GTU_F_CAPEDGE 3:2
`define GTU_F_CLR 4
`define GTU_F_RLWRAP 5
// Reset values
`define GTU_RST_CTL 16'h0000
`define GTU_RST_CRCTL 16'h0000
// Finest resolution in system clocks, as log2
`define GTU_M1_MIN_LOG2 4'h2
`define GTU_M2_MIN_LOG2 4'h1
`endif

// ### core/gtu_timer.v
// One 16-bit up/down timer with load and wrap detection
`timescale 1ns/1ps
module gtu_timer #(
  parameter W = 16
) (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire ce_i,
  input wire wr_i,
  input wire [W-1:0] wr_val_i,
  input wire load_i,
  input wire [W-1:0] load_val_i,
  input wire cnt_en_i,
  input wire up_i,
  output wire [W-1:0] value_o,
  output wire wrap_o
);
  reg [W-1:0] value_q;
  wire [W-1:0] one;

  assign one = {{(W-1){1'b0}}, 1'b1};
  assign value_o = value_q;
  assign wrap_o = cnt_en_i & (up_i ? (&value_q) : ~(|value_q));

  always @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
      value_q <= {W{1'b0}};
    else if (ce_i)
    begin
      // Software write beats hardware load, load beats counting
      if (wr_i)
        value_q <= wr_val_i;
      else if (load_i)
        value_q <= load_val_i;
      else if (cnt_en_i)
        value_q <= up_i ? value_q + one : value_q - one;
    end
  end
endmodule

// ### core/gtu_top.v
// Five-timer general purpose timer unit with Wishbone register access
//
// Our own choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "gtu_defines.vh"
module gtu_top (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire ce_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [4:0] timer_input_pin_i,
  input wire [3:0] timer_dir_pin_i,
  input wire capture_trigger_pin_i,
  output wire core_a_toggle_out_o,
  output wire core_b_toggle_out_o,
  output reg compare_array_timebase_o
);
  localparam NT = 5;
  localparam NP = 10;
  localparam ID_AA = 0;
  localparam ID_CA = 1;
  localparam ID_AB = 2;
  localparam ID_AC = 3;
  localparam ID_CB = 4;

  // Pin vector: inputs 0..4, direction 5..8, capture 9
  wire [NP-1:0] pin_raw;
  reg [NP-1:0] pin_m_q;
  reg [NP-1:0] pin_s_q;
  reg [NP-1:0] pin_d_q;

  reg [16*NT-1:0] ctl_q;
  reg [15:0] crctl_q;
  reg [15:0] capture_reload_reg_q;
  reg [NT-1:0] wrap_flag_q;
  reg latch_a_q;
  reg latch_b_q;
  reg [9:0] pre_q;

  wire [16*NT-1:0] val_w;
  wire [NT-1:0] wrap_w;
  wire [NT-1:0] cnt_en_w;
  wire [NT-1:0] up_w;
  wire [NT-1:0] load_w;
  wire [16*NT-1:0] load_val_w;
  wire [NT-1:0] wr_cnt_w;
  wire [NT-1:0] pin_ev_w;

  wire req;
  wire wr_stb;
  wire [5:0] idx;
  wire [15:0] wr_word;
  wire [5:0] cnt_off;

  function edge_hit;
    input cur;
    input prev;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: edge_hit = cur & ~prev;
        2'h1: edge_hit = ~cur & prev;
        2'h2: edge_hit = cur ^ prev;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  // True once per 2^n system clocks
  function ptick;
    input [9:0] c;
    input [3:0] n;
    reg [9:0] m;
    begin
      m = ~(10'h3FF << n);
      ptick = ((c & m) == m);
    end
  endfunction

  function [15:0] merge16;
    input [15:0] old;
    input [15:0] nw;
    input [1:0] sel;
    begin
      merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  assign pin_raw = {capture_trigger_pin_i, timer_dir_pin_i, timer_input_pin_i};

  always @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      pin_m_q <= {NP{1'b0}};
      pin_s_q <= {NP{1'b0}};
      pin_d_q <= {NP{1'b0}};
    end
    else if (ce_i)
    begin
      pin_m_q <= pin_raw;
      pin_s_q <= pin_m_q;
      pin_d_q <= pin_s_q;
    end
  end

  // Shared prescaler counter, each timer taps its own length
  always @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
      pre_q <= 10'h000;
    else if (ce_i)
      pre_q <= pre_q + 10'h001;
  end

  // Wishbone classic: ack one cycle after strobe, then drop
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_stb = req & wb_we_i;
  assign idx = wb_adr_i[7:2];
  assign wr_word = wb_dat_i[15:0];
  // Narrow offset, a 32-bit subtraction would index out of range
  assign cnt_off = idx - `GTU_IDX_CNT0;

  always @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else if (ce_i)
    begin
      wb_ack_o <= req;
      if (req & ~wb_we_i)
      begin
        wb_dat_o <= 32'h00000000;
        if (idx < `GTU_IDX_CNT0)
          wb_dat_o[15:0] <= ctl_q[16*idx[2:0] +: 16];
        else if (idx < `GTU_IDX_CAPTURE_RELOAD_REG)
          wb_dat_o[15:0] <= val_w[16*cnt_off[2:0] +: 16];
        else if (idx == `GTU_IDX_CAPTURE_RELOAD_REG)
          wb_dat_o[15:0] <= capture_reload_reg_q;
        else if (idx == `GTU_IDX_CRCTL)
          wb_dat_o[15:0] <= crctl_q;
        else if (idx == `GTU_IDX_STAT)
          wb_dat_o[6:0] <= {latch_b_q, latch_a_q, wrap_flag_q};
      end
    end
  end

  // Control registers; unmapped writes are acknowledged and dropped
  always @(posedge sys_clk_i)
  begin : ctl_regs
    integer k;
    if (!reset_n_i)
    begin
      ctl_q <= {NT{`GTU_RST_CTL}};
      crctl_q <= `GTU_RST_CRCTL;
    end
    else if (ce_i & wr_stb)
    begin
      for (k = 0; k < NT; k = k + 1)
        if (idx == k)
          ctl_q[16*k +: 16] <= merge16(ctl_q[16*k +: 16], wr_word, wb_sel_i[1:0]);
      if (idx == `GTU_IDX_CRCTL)
        crctl_q <= merge16(crctl_q, wr_word, wb_sel_i[1:0]);
    end
  end

  // Sticky wrap flags, write one to clear; a new wrap beats the clear
  always @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
      wrap_flag_q <= {NT{1'b0}};
    else if (ce_i)
    begin
      if (wr_stb && idx == `GTU_IDX_STAT && wb_sel_i[0])
        wrap_flag_q <= (wrap_flag_q & ~wr_word[NT-1:0]) | wrap_w;
      else
        wrap_flag_q <= wrap_flag_q | wrap_w;
    end
  end

  // Toggle latches and timebase tick
  wire la_rise;
  wire la_fall;
  wire lb_rise;
  wire lb_fall;
  assign la_rise = wrap_w[ID_CA] & ~latch_a_q;
  assign la_fall = wrap_w[ID_CA] & latch_a_q;
  assign lb_rise = wrap_w[ID_CB] & ~latch_b_q;
  assign lb_fall = wrap_w[ID_CB] & latch_b_q;

  always @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      latch_a_q <= 1'b0;
      latch_b_q <= 1'b0;
      compare_array_timebase_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wrap_w[ID_CA])
        latch_a_q <= ~latch_a_q;
      if (wrap_w[ID_CB])
        latch_b_q <= ~latch_b_q;
      compare_array_timebase_o <= wrap_w[ID_CB];
    end
  end

  // Latch outputs only when enabled on the core timer
  assign core_a_toggle_out_o = latch_a_q & ctl_q[16*ID_CA + `GTU_F_OUTEN];
  assign core_b_toggle_out_o = latch_b_q & ctl_q[16*ID_CB + `GTU_F_OUTEN];

  genvar i;
  generate
    for (i = 0; i < NT; i = i + 1)
    begin : g_tmr
      wire [15:0] c;
      wire m1;
      wire has_dir;
      wire pin_l;
      wire dir_l;
      wire dir_ev;
      wire pin_chg;
      wire tick;
      wire gate;
      wire chain_ev;
      wire lat_r;
      wire lat_f;
      reg en;
      reg up;

      assign c = ctl_q[16*i +: 16];
      assign m1 = (i < ID_AC);
      // aux C has no direction pin
      assign has_dir = (i != ID_AC);
      assign pin_l = pin_s_q[i];
      assign dir_l = has_dir ? pin_s_q[(i == ID_CB) ? 8 : 5 + i] : 1'b0;
      assign dir_ev = has_dir ? (pin_s_q[(i == ID_CB) ? 8 : 5 + i]
                               ^ pin_d_q[(i == ID_CB) ? 8 : 5 + i]) : 1'b0;
      assign pin_chg = pin_s_q[i] ^ pin_d_q[i];
      assign pin_ev_w[i] = edge_hit(pin_s_q[i], pin_d_q[i], c[`GTU_F_EDGE]);
      // first module divides by at least four
      // second module divides by at least two
      assign tick = ptick(pre_q, (m1 ? `GTU_M1_MIN_LOG2 : `GTU_M2_MIN_LOG2)
                                 + {1'b0, c[`GTU_F_PS]});
      assign gate = pin_l ^ c[`GTU_F_GPOL];
      assign lat_r = m1 ? la_rise : lb_rise;
      assign lat_f = m1 ? la_fall : lb_fall;
      assign chain_ev = edge_hit(lat_r, lat_f, c[`GTU_F_EDGE]);

      always @*
      begin
        en = 1'b0;
        up = ~(c[`GTU_F_DOWN] ^ (c[`GTU_F_EXTDIR] & dir_l));
        case (c[`GTU_F_MODE])
          `GTU_MODE_TIMER: en = tick;
          `GTU_MODE_GATED: en = tick & gate;
          `GTU_MODE_COUNT: en = pin_ev_w[i];
          `GTU_MODE_ENC:
          begin
            // quadrature decode, second module has none
            en = m1 & (pin_chg | dir_ev);
            up = pin_chg ? (pin_l ^ dir_l) : ~(pin_l ^ dir_l);
          end
          default: en = 1'b0;
        endcase
        if (i != ID_CA && i != ID_CB)
        begin
          case (c[`GTU_F_AUXFN])
            `GTU_AUX_NONE: en = en;
            // capture or reload role stops the timer
            `GTU_AUX_RELOAD: en = 1'b0;
            `GTU_AUX_CAPTURE: en = 1'b0;
            // aux C clocked by core B latch, aux A and B by core A latch
            `GTU_AUX_CHAIN: en = chain_ev;
            default: en = 1'b0;
          endcase
        end
      end

      assign cnt_en_w[i] = c[`GTU_F_RUN] & en;
      assign up_w[i] = up;
      assign wr_cnt_w[i] = wr_stb && (idx == `GTU_IDX_CNT0 + i);

      gtu_timer #(
        .W(16)
      ) u_tmr (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .wr_i(wr_cnt_w[i]),
        .wr_val_i(merge16(val_w[16*i +: 16], wr_word, wb_sel_i[1:0])),
        .load_i(load_w[i]),
        .load_val_i(load_val_w[16*i +: 16]),
        .cnt_en_i(cnt_en_w[i]),
        .up_i(up_w[i]),
        .value_o(val_w[16*i +: 16]),
        .wrap_o(wrap_w[i])
      );
    end
  endgenerate

  // Reload triggers of aux A and B
  function rl_trig;
    input [15:0] c;
    input pe;
    begin
      if (c[`GTU_F_AUXFN] != `GTU_AUX_RELOAD)
        rl_trig = 1'b0;
      else
      begin
        case (c[`GTU_F_RLSEL])
          2'h0: rl_trig = pe;
          2'h1: rl_trig = la_rise;
          2'h2: rl_trig = la_fall;
          default: rl_trig = 1'b0;
        endcase
      end
    end
  endfunction

  wire [15:0] c_aa;
  wire [15:0] c_ab;
  wire rl_a;
  wire rl_b;
  wire cap_a;
  wire cap_b;
  assign c_aa = ctl_q[16*ID_AA +: 16];
  assign c_ab = ctl_q[16*ID_AB +: 16];
  // reload by pin or latch edge
  assign rl_a = rl_trig(c_aa, pin_ev_w[ID_AA]);
  assign rl_b = rl_trig(c_ab, pin_ev_w[ID_AB]);
  assign cap_a = (c_aa[`GTU_F_AUXFN] == `GTU_AUX_CAPTURE) & pin_ev_w[ID_AA];
  assign cap_b = (c_ab[`GTU_F_AUXFN] == `GTU_AUX_CAPTURE) & pin_ev_w[ID_AB];

  // Second module capture source
  wire cap_pin_ev;
  wire ca_in_chg;
  wire ca_dir_chg;
  reg cr_ev;
  assign cap_pin_ev = edge_hit(pin_s_q[9], pin_d_q[9], crctl_q[`GTU_F_CAPEDGE]);
  assign ca_in_chg = pin_s_q[ID_CA] ^ pin_d_q[ID_CA];
  assign ca_dir_chg = pin_s_q[6] ^ pin_d_q[6];

  always @*
  begin
    // capture pin or core A pins as capture source
    case (crctl_q[`GTU_F_CAPSRC])
      2'h0: cr_ev = cap_pin_ev;
      2'h1: cr_ev = ca_in_chg;
      2'h2: cr_ev = ca_dir_chg;
      2'h3: cr_ev = ca_in_chg | ca_dir_chg;
      default: cr_ev = 1'b0;
    endcase
  end

  always @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
      capture_reload_reg_q <= 16'h0000;
    else if (ce_i)
    begin
      if (cr_ev)
        capture_reload_reg_q <= val_w[16*ID_AC +: 16];
      else if (wr_stb && idx == `GTU_IDX_CAPTURE_RELOAD_REG)
        capture_reload_reg_q <= merge16(capture_reload_reg_q, wr_word, wb_sel_i[1:0]);
    end
  end

  // aux A wins if both fire at once; opposite edges alternate
  assign load_w[ID_CA] = rl_a | rl_b;
  assign load_val_w[16*ID_CA +: 16] = rl_a ? val_w[16*ID_AA +: 16] : val_w[16*ID_AB +: 16];
  assign load_w[ID_AA] = cap_a;
  assign load_val_w[16*ID_AA +: 16] = val_w[16*ID_CA +: 16];
  assign load_w[ID_AB] = cap_b;
  assign load_val_w[16*ID_AB +: 16] = val_w[16*ID_CA +: 16];
  assign load_w[ID_AC] = cr_ev & crctl_q[`GTU_F_CLR];
  assign load_val_w[16*ID_AC +: 16] = 16'h0000;
  assign load_w[ID_CB] = wrap_w[ID_CB] & crctl_q[`GTU_F_RLWRAP];
  assign load_val_w[16*ID_CB +: 16] = capture_reload_reg_q;
endmodule

// ### dv/gtu_properties.sv
// Bus and output checks of the timer unit
`timescale 1ns/1ps
module gtu_properties (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire ce_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire core_a_toggle_out_o,
  input wire core_b_toggle_out_o,
  input wire compare_array_timebase_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  AST_ACK_ONE: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_TAKEN: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("request not answered next cycle");
  AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  AST_DAT_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read data not zero");
  AST_UNMAPPED: assert property ($rose(wb_ack_o) && !$past(wb_we_i) && $past(wb_adr_i) > 8'h33
    |-> wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");
  AST_STAT_RSVD: assert property ($rose(wb_ack_o) && !$past(wb_we_i) && $past(wb_adr_i) >= 8'h30
    && $past(wb_adr_i) <= 8'h33 |-> wb_dat_o[15:7] == 9'h000)
    else $error("status spare bits set");
  AST_TB_PULSE: assert property (compare_array_timebase_o && ce_i |=> !compare_array_timebase_o)
    else $error("timebase pulse too long");
  AST_CE_HOLD: assert property (!ce_i |=> $stable(core_a_toggle_out_o)
    && $stable(core_b_toggle_out_o) && $stable(wb_ack_o))
    else $error("state moved while clock enable low");
endmodule
bind gtu_top gtu_properties u_props (.sys_clk_i, .reset_n_i, .ce_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .core_a_toggle_out_o, .core_b_toggle_out_o,
  .compare_array_timebase_o);

// ### dv/gtu_pin_model.sv
// Outside event, gate and quadrature source on the timer pins
`timescale 1ns/1ps
module gtu_pin_model (
  input wire sys_clk_i,
  output logic [4:0] in_pins_o,
  output logic [3:0] dir_pins_o,
  output logic cap_pin_o
);
  initial
  begin
    in_pins_o = 5'h00;
    dir_pins_o = 4'h0;
    cap_pin_o = 1'b0;
  end
  // Long enough for the two-stage sync and the count edge
  task hold;
    repeat (4) @(posedge sys_clk_i);
  endtask
  task drive_in(input int i, input logic v);
    @(posedge sys_clk_i);
    in_pins_o[i] <= v;
    hold;
  endtask
  task drive_dir(input int i, input logic v);
    @(posedge sys_clk_i);
    dir_pins_o[i] <= v;
    hold;
  endtask
  task pulse(input int i);
    drive_in(i, 1'b1);
    drive_in(i, 1'b0);
  endtask
  task cap_pulse;
    @(posedge sys_clk_i);
    cap_pin_o <= 1'b1;
    hold;
    cap_pin_o <= 1'b0;
    hold;
  endtask
  // quadrature, only one of A and B moves per step
  task enc(input logic fwd);
    if ((in_pins_o[1] == dir_pins_o[1]) == fwd)
      drive_in(1, !in_pins_o[1]);
    else
      drive_dir(1, !dir_pins_o[1]);
  endtask
endmodule

// ### dv/testbench.sv
// Self-checking bench for the timer unit
`timescale 1ns/1ps
module testbench;
  localparam int M1_DIV = 4;
  localparam int M2_DIV = 2;
  localparam int LIMIT = 20000;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic tog_a;
  logic tog_b;
  logic tbase;
  logic [4:0] in_pins;
  logic [3:0] dir_pins;
  logic cap_pin;
  logic [15:0] rd;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int tb_seen = 0;
  gtu_pin_model pm (.sys_clk_i(sys_clk_i), .in_pins_o(in_pins), .dir_pins_o(dir_pins),
    .cap_pin_o(cap_pin));
  gtu_top dut (.sys_clk_i, .reset_n_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .timer_input_pin_i(in_pins),
    .timer_dir_pin_i(dir_pins), .capture_trigger_pin_i(cap_pin),
    .core_a_toggle_out_o(tog_a), .core_b_toggle_out_o(tog_b),
    .compare_array_timebase_o(tbase));
  always #5 sys_clk_i = ~sys_clk_i;
  task stop_test;
    $display("Comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge sys_clk_i)
  begin
    cycles <= cycles + 1;
    if (tbase === 1'b1)
      tb_seen <= tb_seen + 1;
    if (cycles == LIMIT)
    begin
      errors = errors + 1;
      $display("Error at %0t: timeout", $time);
      stop_test;
    end
  end
  // Ack sampled before the edge's own updates land
  task xfer(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge sys_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do
      @(posedge sys_clk_i);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_rng(input logic [15:0] got, input int lo, input int hi);
    n_tests++;
    if (!(^got !== 1'bx && got >= lo && got <= hi))
    begin
      errors++;
      $display("Error at %0t: got %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task wr(input logic [5:0] i, input logic [31:0] d);
    xfer(1'b1, {i, 2'b00}, 4'h3, d);
  endtask
  task rc(input logic [5:0] i, input logic [15:0] e);
    xfer(1'b0, {i, 2'b00}, 4'h3, 32'h00000000);
    chk(rd, e);
  endtask
  task rr(input logic [5:0] i, input int lo, input int hi);
    xfer(1'b0, {i, 2'b00}, 4'h3, 32'h00000000);
    chk_rng(rd, lo, hi);
  endtask
  task wait_clk(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  initial
  begin
    wait_clk(6);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 16; i++)
      rc(i[5:0], 16'h0000);
    wr(6'h05, 32'h0001FFFF);
    rc(6'h05, 16'hFFFF);
    // Byte lanes: sel[0] low, sel[1] high, the rest and adr[1:0] ignored
    xfer(1'b1, 8'h17, 4'h1, 32'hFFFF0012);
    rc(6'h05, 16'hFF12);
    xfer(1'b1, 8'h16, 4'h2, 32'h00003400);
    xfer(1'b1, 8'h15, 4'hC, 32'hFFFFFFFF);
    xfer(1'b0, 8'h17, 4'hF, 32'h00000000);
    chk(rd, 16'h3412);
    wr(6'h0E, 32'h00001234);
    rc(6'h0E, 16'h0000);
    $display("Test registers done");
    wr(6'h01, 32'h00000006);
    repeat (3) pm.pulse(1);
    rc(6'h06, 16'h0003);
    pm.drive_dir(1, 1'b1);
    wr(6'h01, 32'h00000016);
    pm.pulse(1);
    rc(6'h06, 16'h0002);
    pm.drive_dir(1, 1'b0);
    wr(6'h01, 32'h0000000E);
    pm.pulse(1);
    rc(6'h06, 16'h0001);
    repeat (2) pm.pulse(1);
    rc(6'h06, 16'hFFFF);
    rc(6'h0C, 16'h0022);
    wr(6'h01, 32'h0000080E);
    chk({15'h0000, tog_a}, 16'h0001);
    wr(6'h0C, 32'h00000002);
    rc(6'h0C, 16'h0020);
    wr(6'h01, 32'h00000000);
    $display("Test counter done");
    wr(6'h05, 32'h00000000);
    wr(6'h00, 32'h00000004);
    wr(6'h04, 32'h00000004);
    wait_clk(200);
    ce_i <= 1'b0;
    wait_clk(200);
    ce_i <= 1'b1;
    wait_clk(200);
    wr(6'h00, 32'h00000000);
    wr(6'h04, 32'h00000000);
    rr(6'h05, 400 / M1_DIV - 3, 400 / M1_DIV + 3);
    rr(6'h09, 400 / M2_DIV - 6, 400 / M2_DIV + 6);
    wr(6'h07, 32'h00000000);
    wr(6'h02, 32'h00000005);
    wait_clk(200);
    rc(6'h07, 16'h0000);
    pm.drive_in(2, 1'b1);
    wait_clk(200);
    wr(6'h02, 32'h00000000);
    rr(6'h07, 200 / M1_DIV - 3, 200 / M1_DIV + 5);
    pm.drive_in(2, 1'b0);
    wr(6'h07, 32'h00000064);
    pm.drive_dir(2, 1'b1);
    wr(6'h02, 32'h00000035);
    wait_clk(80);
    wr(6'h02, 32'h00000000);
    rr(6'h07, 100 - 84 / M1_DIV - 3, 100 - 84 / M1_DIV + 3);
    pm.drive_dir(2, 1'b0);
    wr(6'h05, 32'h00000000);
    wr(6'h00, 32'h00000104);
    wait_clk(160);
    wr(6'h00, 32'h00000000);
    rr(6'h05, 160 / (2 * M1_DIV) - 3, 160 / (2 * M1_DIV) + 3);
    wr(6'h05, 32'h00000000);
    wr(6'h00, 32'h00000096);
    pm.drive_dir(0, 1'b1);
    pm.pulse(0);
    rc(6'h05, 16'hFFFE);
    pm.drive_dir(0, 1'b0);
    wr(6'h00, 32'h00000000);
    rc(6'h0C, 16'h0021);
    wr(6'h0C, 32'h00000001);
    $display("Test timer done");
    wr(6'h06, 32'h00000000);
    wr(6'h01, 32'h00000007);
    repeat (4) pm.enc(1'b1);
    rc(6'h06, 16'h0004);
    pm.enc(1'b0);
    rc(6'h06, 16'h0003);
    wr(6'h01, 32'h00000000);
    wr(6'h06, 32'h00001234);
    wr(6'h00, 32'h00002004);
    pm.pulse(0);
    wait_clk(20);
    rc(6'h05, 16'h1234);
    wr(6'h05, 32'h0000ABCD);
    wr(6'h00, 32'h00001000);
    pm.pulse(0);
    rc(6'h06, 16'hABCD);
    wr(6'h05, 32'h00001111);
    wr(6'h07, 32'h00002222);
    wr(6'h00, 32'h00005000);
    wr(6'h02, 32'h00009000);
    wr(6'h06, 32'h0000FFFF);
    wr(6'h01, 32'h00000006);
    pm.pulse(1);
    rc(6'h06, 16'h2222);
    wr(6'h06, 32'h0000FFFF);
    pm.pulse(1);
    rc(6'h06, 16'h1111);
    wr(6'h01, 32'h00000000);
    wr(6'h00, 32'h00000000);
    wr(6'h02, 32'h00000000);
    $display("Test capture reload done");
    wr(6'h08, 32'h000055AA);
    wr(6'h0B, 32'h00000010);
    pm.cap_pulse;
    rc(6'h0A, 16'h55AA);
    rc(6'h08, 16'h0000);
    wr(6'h08, 32'h00000077);
    wr(6'h0B, 32'h00000001);
    pm.drive_in(1, 1'b1);
    rc(6'h0A, 16'h0077);
    wr(6'h08, 32'h00000099);
    wr(6'h0B, 32'h00000002);
    pm.drive_dir(1, 1'b0);
    rc(6'h0A, 16'h0099);
    wr(6'h0A, 32'h00000100);
    wr(6'h0B, 32'h00000020);
    wr(6'h09, 32'h0000FFFF);
    wr(6'h04, 32'h00000806);
    pm.pulse(4);
    rc(6'h09, 16'h0100);
    chk(tb_seen[15:0], 16'h0001);
    rc(6'h0C, 16'h0072);
    chk({15'h0000, tog_b}, 16'h0001);
    wr(6'h0B, 32'h00000000);
    wr(6'h08, 32'h00000000);
    wr(6'h03, 32'h00003084);
    wr(6'h09, 32'h0000FFFF);
    pm.pulse(4);
    rc(6'h08, 16'h0001);
    wr(6'h03, 32'h00000046);
    wr(6'h04, 32'h00000016);
    pm.drive_dir(3, 1'b1);
    pm.pulse(4);
    rc(6'h09, 16'hFFFF);
    pm.drive_dir(3, 1'b0);
    repeat (2) pm.pulse(3);
    rc(6'h08, 16'h0003);
    wr(6'h0B, 32'h00000004);
    pm.cap_pulse;
    rc(6'h0A, 16'h0003);
    wr(6'h04, 32'h00000000);
    wr(6'h03, 32'h00000000);
    $display("Test second module done");
    stop_test;
  end
endmodule
